// [hdl/sram_ctrl_defs.svh]
// Timing and geometry constants for the static memory controller
`ifndef SRAM_CTRL_DEFS_SVH
`define SRAM_CTRL_DEFS_SVH

`define ADDR_W 17
`define DATA_W 8
`define CLK_PERIOD_NS 100
// Slowest grade figures, in ns
`define CYCLE_TIME_NS 12
`define WRITE_PULSE_WIDTH_NS 10
`define DATA_SETUP_TO_STROBE_END_NS 6
`define OUTPUT_ON_ACCESS_DELAY_NS 6
`define SELECT_RELEASE_DELAY_NS 6
// Least times round up, never below one cycle
`define CYCLE_TIME_CYC ((`CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC ((`WRITE_PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_NS (`CYCLE_TIME_NS + `OUTPUT_ON_ACCESS_DELAY_NS)
`define READ_WAIT_CYC ((`READ_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_CYC ((`SELECT_RELEASE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4

`endif

// [hdl/sram_ctrl_pkg.sv]
// Types shared by the static memory controller
`include "sram_ctrl_defs.svh"
package sram_ctrl_pkg;
    // Request from user side
    typedef struct packed {
        logic write;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } mem_req_t;
    // Memory pin bundle, strobes active low
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic [`DATA_W-1:0] dq_out;
        logic dq_oe;
    } mem_pins_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_DONE,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_END,
        ST_TURN
    } ctrl_state_t;
endpackage : sram_ctrl_pkg

// [hdl/sram_ctrl.sv]
// Host-side controller for an asynchronous 128K x 8 static memory
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_defs.svh"

module sram_ctrl
    import sram_ctrl_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // User request
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [`ADDR_W-1:0] req_addr_i,
    input wire logic [`DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [`DATA_W-1:0] rd_data_o,
    // Memory pins
    output logic [`ADDR_W-1:0] mem_addr_o,
    output logic mem_sel_n_o,
    output logic mem_oe_n_o,
    output logic mem_we_n_o,
    output logic [`DATA_W-1:0] mem_dq_o,
    output logic mem_dq_oe_o,
    input wire logic [`DATA_W-1:0] mem_dq_i
);

    // Sequencer state, pin image and down-counter
    ctrl_state_t state_reg, state_next;
    mem_pins_t pins_reg, pins_next;
    mem_req_t req_in;
    logic [`CNT_W-1:0] cnt_reg, cnt_next;
    // Read capture path
    logic [`DATA_W-1:0] dq_meta_reg, dq_sync_reg, rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;

    // Pack request fields
    assign req_in = '{write: req_write_i, addr: req_addr_i, wdata: req_wdata_i};
    // Take a request only while idle; later ones are dropped
    wire accept = (state_reg == ST_IDLE) && req_valid_i;
    wire cnt_done = (cnt_reg == '0);

    // Count load helper
    // The counter runs down to zero, so a load of n waits n cycles
    function automatic logic [`CNT_W-1:0] load_cnt(input integer cycles);
        load_cnt = `CNT_W'(cycles - 1);
    endfunction : load_cnt

    // Read: address, select and output enable move together, then the
    // byte is captured once it has crossed both synchroniser stages
    // Write: address and select settle a cycle before the strobe falls,
    // and the strobe rises a cycle before select and data let go
    // Every step lasts a whole 100 ns cycle, well above each least time,
    // so all grades are served by one sequence
    // Next-state and pin sequencing
    always_comb begin
        state_next = state_reg;
        pins_next = pins_reg;
        cnt_next = cnt_done ? cnt_reg : cnt_reg - `CNT_W'(1);
        rd_data_next = rd_data_reg;
        rd_valid_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    pins_next.addr = req_in.addr;
                    pins_next.sel_n = 1'b0;
                    pins_next.dq_out = req_in.wdata;
                    if (req_in.write) begin
                        pins_next.oe_n = 1'b1;
                        pins_next.we_n = 1'b1;
                        pins_next.dq_oe = 1'b0;
                        state_next = ST_WR_SETUP;
                    end else begin
                        pins_next.we_n = 1'b1;
                        pins_next.oe_n = 1'b0;
                        pins_next.dq_oe = 1'b0;
                        // Access time plus two synchroniser stages
                        cnt_next = load_cnt(`READ_WAIT_CYC + 2);
                        state_next = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_WAIT: begin
                if (cnt_done) begin
                    state_next = ST_RD_DONE;
                end
            end
            ST_RD_DONE: begin
                rd_data_next = dq_sync_reg;
                rd_valid_next = 1'b1;
                // Release select and output enable together
                pins_next.oe_n = 1'b1;
                pins_next.sel_n = 1'b1;
                cnt_next = load_cnt(`RELEASE_CYC);
                state_next = ST_TURN;
            end
            ST_WR_SETUP: begin
                // Output enable has been high a cycle, so the memory is off the bus
                // drive data only after memory is quiet
                pins_next.dq_oe = 1'b1;
                pins_next.we_n = 1'b0;
                cnt_next = load_cnt(`WRITE_PULSE_CYC);
                state_next = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                if (cnt_done) begin
                    pins_next.we_n = 1'b1;
                    state_next = ST_WR_END;
                end
            end
            ST_WR_END: begin
                // Bus handed back one cycle after the strobe rose
                // data held after strobe rise
                pins_next.sel_n = 1'b1;
                pins_next.dq_oe = 1'b0;
                cnt_next = load_cnt(`CYCLE_TIME_CYC);
                state_next = ST_TURN;
            end
            ST_TURN: begin
                // Select stays high so the memory can let go of the bus
                // margin before next access
                if (cnt_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                // Unused codes fall back to idle
                state_next = ST_IDLE;
            end
        endcase
    end

    // State registers
    // Synchronous reset wins over the clock enable
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= ST_IDLE;
            pins_reg <= '{addr: '0, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_out: '0, dq_oe: 1'b0};
            cnt_reg <= '0;
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            pins_reg <= pins_next;
            cnt_reg <= cnt_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // Two-stage synchroniser on memory data
    // The memory answers with no clock, so its bus may move at any time;
    // only the second stage is read by the sequencer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
        end else if (ce_i) begin
            dq_meta_reg <= mem_dq_i;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    // Ready is registered from the next state,
    // so it falls at the very edge that takes a request
    logic ready_reg;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ready_reg <= 1'b0;
        end else if (ce_i) begin
            ready_reg <= (state_next == ST_IDLE);
        end
    end

    // Outputs from flip-flops
    // No logic after the registers, so no glitch reaches the memory pins
    assign req_ready_o = ready_reg;
    assign rd_valid_o = rd_valid_reg;
    assign rd_data_o = rd_data_reg;
    assign mem_addr_o = pins_reg.addr;
    assign mem_sel_n_o = pins_reg.sel_n;
    assign mem_oe_n_o = pins_reg.oe_n;
    assign mem_we_n_o = pins_reg.we_n;
    assign mem_dq_o = pins_reg.dq_out;
    assign mem_dq_oe_o = pins_reg.dq_oe;

endmodule : sram_ctrl
`default_nettype wire

// [bench/sram_model.sv]
// Behavioural model of the static memory on the far side
`timescale 1ns/10ps
`default_nettype none
module sram_model (
    // Clock for bus decay only
    input wire logic clk_i,
    // Memory pins
    input wire logic [16:0] addr_i,
    input wire logic sel_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [7:0] host_dq_i,
    input wire logic host_oe_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [0:131071];
    logic [7:0] last;
    wire drv = !sel_n_i && !oe_n_i && we_n_i;
    wire wr_on = !sel_n_i && !we_n_i;
    always @(negedge wr_on) begin
        mem[addr_i] <= host_dq_i;
    end
    assign dq_o = host_oe_i ? host_dq_i : drv ? mem[addr_i] : ~last;
    always @(posedge clk_i) last <= dq_o;
endmodule : sram_model
`default_nettype wire

// [bench/sram_ctrl_chk.sv]
// Pin timing checks for the memory controller
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_chk (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // User side
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [16:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    input wire logic req_ready_o,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    // Memory pins
    input wire logic [16:0] mem_addr_o,
    input wire logic mem_sel_n_o,
    input wire logic mem_oe_n_o,
    input wire logic mem_we_n_o,
    input wire logic [7:0] mem_dq_o,
    input wire logic mem_dq_oe_o,
    input wire logic [7:0] mem_dq_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    rd_no_write_a:
    assert property (!mem_oe_n_o |-> mem_we_n_o) else $error("strobe low in read");
    rd_seq_a:
    assert property ($fell(mem_oe_n_o) |-> (!mem_oe_n_o && !mem_sel_n_o)[*4] ##1 (rd_valid_o && mem_oe_n_o))
        else $error("read sequence wrong");
    addr_hold_a:
    assert property (!mem_sel_n_o && !$past(mem_sel_n_o) |-> $stable(mem_addr_o)) else $error("address moved");
    wr_strobe_a:
    assert property ($fell(mem_we_n_o) |-> !mem_sel_n_o && mem_oe_n_o && mem_dq_oe_o && $stable(mem_addr_o)
        ##1 $rose(mem_we_n_o) && !mem_sel_n_o) else $error("write strobe wrong");
    wr_hold_a:
    assert property ($rose(mem_we_n_o) |-> $stable(mem_dq_o) && mem_dq_oe_o ##1 mem_sel_n_o && !mem_dq_oe_o)
        else $error("write hold wrong");
    no_fight_a:
    assert property (mem_dq_oe_o |-> mem_oe_n_o && !mem_sel_n_o) else $error("bus contention");
    busy_ready_a:
    assert property (!mem_sel_n_o |-> !req_ready_o) else $error("ready while busy");
    rd_pulse_a:
    assert property (rd_valid_o |=> !rd_valid_o && $stable(rd_data_o)) else $error("read pulse wrong");
    c_rd: cover property ($fell(mem_oe_n_o));
    c_wr: cover property ($fell(mem_we_n_o));
    c_dv: cover property (rd_valid_o);
endmodule : sram_ctrl_chk
bind sram_ctrl sram_ctrl_chk i_chk (.*);
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the memory controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i, resetn_i, ce_i, req_valid_i, req_write_i, req_ready_o, rd_valid_o;
    logic mem_sel_n_o, mem_oe_n_o, mem_we_n_o, mem_dq_oe_o;
    logic [16:0] req_addr_i, mem_addr_o;
    logic [7:0] req_wdata_i, rd_data_o, mem_dq_o, mem_dq_i;
    logic [7:0] exp_q[$];
    logic [7:0] shadow [int];
    logic [16:0] pool [16];
    int failures = 0, n_compared = 0, cyc = 0;
    sram_ctrl i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .mem_addr_o(mem_addr_o), .mem_sel_n_o(mem_sel_n_o), .mem_oe_n_o(mem_oe_n_o),
        .mem_we_n_o(mem_we_n_o), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o), .mem_dq_i(mem_dq_i));
    sram_model i_mem (.clk_i(clk_i), .addr_i(mem_addr_o), .sel_n_i(mem_sel_n_o), .oe_n_i(mem_oe_n_o),
        .we_n_i(mem_we_n_o), .host_dq_i(mem_dq_o), .host_oe_i(mem_dq_oe_o), .dq_o(mem_dq_i));
    task check(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    task conclude;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // One request; a read notes its expected byte
    task op(input logic w, input logic [16:0] a, input logic [7:0] d);
        while (req_ready_o !== 1'b1) @(negedge clk_i);
        {req_write_i, req_addr_i, req_wdata_i, req_valid_i} = {w, a, d, 1'b1};
        if (w) shadow[a] = d;
        else exp_q.push_back(shadow[a]);
        @(negedge clk_i);
        req_valid_i = 0;
        check(8'(req_ready_o), 8'h0); // no new take while busy
    endtask : op
    // Compare each read result with the oldest note
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 4000) begin
            failures++;
            conclude();
        end
        if (rd_valid_o === 1'b1) check(8'(exp_q.size() > 0), 8'h1); // a note waits
        if (rd_valid_o === 1'b1 && exp_q.size() > 0) check(rd_data_o, exp_q.pop_front());
    end
    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        {resetn_i, ce_i, req_valid_i, req_write_i, req_addr_i, req_wdata_i} = '0;
        void'($urandom(24));
        repeat (6) @(negedge clk_i);
        {resetn_i, ce_i} = 2'b11;
        for (int i = 0; i < 16; i++) begin
            pool[i] = i == 0 ? 17'h0 : i == 1 ? 17'h1ffff : 17'($urandom);
            op(1, pool[i], 8'($urandom));
        end
        for (int i = 0; i < 40; i++) op(1'($urandom), pool[$urandom % 16], 8'($urandom));
        // Request while busy and while frozen is ignored
        op(0, pool[0], 8'h0);
        {req_write_i, req_wdata_i, req_valid_i} = {1'b1, ~shadow[pool[0]], 1'b1};
        @(negedge clk_i);
        req_valid_i = 0;
        repeat (10) @(negedge clk_i);
        ce_i = 0;
        {req_write_i, req_valid_i} = 2'b11;
        repeat (3) @(negedge clk_i);
        {ce_i, req_valid_i} = 2'b10;
        op(0, pool[0], 8'h0);
        repeat (12) @(negedge clk_i);
        check(8'(exp_q.size()), 8'h0); // every read answered
        conclude();
    end
endmodule : testbench
`default_nettype wire
